// ===== common/muldiv_pkg.sv
/*
 Constants, types and map of the arithmetic unit.
 Assumes one system clock and a byte-wide register port from the core.
*/
package muldiv_pkg;
    localparam logic [7:0] ADDR_POWER     = 8'h87;
    localparam logic [7:0] ADDR_ARITH     = 8'hEF;
    localparam logic [7:0] ADDR_OPB0      = 8'hE9;
    localparam logic [7:0] ADDR_OPB5      = 8'hEE;
    localparam int         NUM_OPB        = 6;
    localparam int         ERR_BIT        = 7;
    localparam int         OVF_BIT        = 6;
    localparam int         DIR_BIT        = 5;
    localparam int         SC_MSB         = 4;
    localparam int         DONE_BIT       = 6;
    localparam logic [7:0] POWER_RESET    = 8'h40;
    localparam logic [7:0] POWER_WMASK    = 8'h83;
    localparam logic [7:0] ARITH_RESET    = 8'h00;
    localparam logic [7:0] OPB_RESET      = 8'h00;
    localparam logic [2:0] IDX_FINAL_DIV  = 3'h5;
    localparam logic [2:0] IDX_FINAL_OTH  = 3'h3;
    localparam logic [4:0] CYC_DIV32      = 5'h11;
    localparam logic [4:0] CYC_DIV16      = 5'h09;
    localparam logic [4:0] CYC_MUL        = 5'h0B;
    localparam logic [4:0] CYC_SHIFT_BASE = 5'h02;
    localparam logic [4:0] CYC_NORM_BASE  = 5'h04;
    localparam logic [31:0] MUL_LIMIT     = 32'h0000FFFF;
    localparam logic [31:0] DIV0_QUOT     = 32'hFFFFFFFF;

    typedef enum logic [1:0] {PH_LOAD, PH_EXEC, PH_READ} phase_t;
    typedef enum logic [2:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} op_t;
    typedef enum logic [3:0] {SEQ_NONE, SEQ_B0, SEQ_B01, SEQ_B012, SEQ_B0123,
                              SEQ_B01234, SEQ_B014, SEQ_B04, SEQ_B041} seq_t;
endpackage

// ===== design/muldiv_unit.sv
/*
 Memory-mapped unsigned multiply, divide, shift and normalize unit.
 Assumes core register strobes are synchronous to CLK, one access a cycle.
*/
module muldiv_unit
    import muldiv_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    output logic            CALC_BUSY
);

    logic [7:0]  opb_reg [NUM_OPB];
    logic [7:0]  opb_next [NUM_OPB];
    logic [7:0]  pkeep_reg, pkeep_next;
    logic        done_reg, done_next;
    logic        err_reg, err_next;
    logic        ovf_reg, ovf_next;
    logic        dir_reg, dir_next;
    logic [4:0]  sc_reg, sc_next;
    logic        armed_reg, armed_next;
    phase_t      phase_reg, phase_next;
    op_t         op_reg, op_next;
    seq_t        seq_reg, seq_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic [47:0] res_reg, res_next;
    logic [4:0]  scres_reg, scres_next;
    logic [7:0]  rdata_reg, rdata_next;

    logic        sel_opb, wr_opb, rd_opb, wr_arith, abort, finish, final_rd;
    logic [2:0]  idx;
    logic [7:0]  m [NUM_OPB];
    op_t         start_op;
    logic [31:0] val32, quot32, prod, shifted;
    logic [15:0] dvs, rem16, quot16;
    logic [4:0]  lz, wsc;
    logic        wdir;

    function automatic logic [4:0] lead_zeros(input logic [31:0] v);
        logic [4:0] n;
        logic       found;
        n = 5'h00;
        found = 1'b0;
        for (int i = 31; i >= 1; i--)
        begin
            if (v[i])
                found = 1'b1;
            else if (!found)
                n = n + 5'h01;
        end
        return n;
    endfunction

    // Access decode
    assign sel_opb  = (SFR_ADDR >= ADDR_OPB0) && (SFR_ADDR <= ADDR_OPB5);
    assign idx      = 3'(SFR_ADDR - ADDR_OPB0);
    assign wr_opb   = SFR_WR && sel_opb;
    assign rd_opb   = SFR_RD && sel_opb;
    assign wr_arith = SFR_WR && (SFR_ADDR == ADDR_ARITH);
    assign abort    = wr_opb && (phase_reg == PH_EXEC);
    assign finish   = (phase_reg == PH_EXEC) && (cnt_reg == 5'h00) && !abort;
    assign final_rd = (phase_reg == PH_READ) && rd_opb
                   && (idx == (((op_reg == OP_DIV32) || (op_reg == OP_DIV16))
                               ? IDX_FINAL_DIV : IDX_FINAL_OTH));
    // Core never waits on the unit
    assign CALC_BUSY = (phase_reg == PH_EXEC);
    assign SFR_RDATA = rdata_reg;

    // Operand bytes with the current write merged in
    always_comb
    begin
        for (int i = 0; i < NUM_OPB; i++)
            m[i] = (wr_opb && (idx == 3'(i))) ? SFR_WDATA : opb_reg[i];
        wdir = wr_arith ? SFR_WDATA[DIR_BIT] : dir_reg;
        wsc  = wr_arith ? SFR_WDATA[SC_MSB:0] : sc_reg;
    end

    // Unsigned arithmetic on the loaded operands
    always_comb
    begin
        val32 = {m[3], m[2], m[1], m[0]};
        dvs   = {m[5], m[4]};
        if (dvs == 16'h0000)
        begin
            quot32 = DIV0_QUOT;
            quot16 = DIV0_QUOT[15:0];
            rem16  = 16'h0000;
        end
        else
        begin
            quot32 = val32 / {16'h0000, dvs};
            quot16 = {m[1], m[0]} / dvs;
            rem16  = (start_op == OP_DIV16) ? ({m[1], m[0]} % dvs)
                                            : 16'(val32 % {16'h0000, dvs});
        end
        prod    = {m[1], m[0]} * {m[5], m[4]};
        lz      = lead_zeros(val32);
        // Zeros enter at the vacated end
        shifted = wdir ? (val32 >> wsc) : (val32 << wsc);
    end

    // Load sequence tracking and operation select
    always_comb
    begin
        seq_next = seq_reg;
        start_op = OP_NONE;
        if (wr_opb)
        begin
            case (idx)
                3'h0: seq_next = SEQ_B0;
                3'h1: seq_next = (seq_reg == SEQ_B0) ? SEQ_B01
                               : (seq_reg == SEQ_B04) ? SEQ_B041 : SEQ_NONE;
                3'h2: seq_next = (seq_reg == SEQ_B01) ? SEQ_B012 : SEQ_NONE;
                3'h3: seq_next = (seq_reg == SEQ_B012) ? SEQ_B0123 : SEQ_NONE;
                3'h4: seq_next = (seq_reg == SEQ_B0) ? SEQ_B04
                               : (seq_reg == SEQ_B01) ? SEQ_B014
                               : (seq_reg == SEQ_B0123) ? SEQ_B01234 : SEQ_NONE;
                3'h5:
                begin
                    seq_next = SEQ_NONE;
                    if (seq_reg == SEQ_B01234)
                        start_op = OP_DIV32;
                    else if (seq_reg == SEQ_B014)
                        start_op = OP_DIV16;
                    else if (seq_reg == SEQ_B041)
                        start_op = OP_MUL;
                end
                default: seq_next = SEQ_NONE;
            endcase
        end
        else if (wr_arith && (seq_reg == SEQ_B0123))
        begin
            seq_next = SEQ_NONE;
            // Zero count means normalize
            start_op = (wsc == 5'h00) ? OP_NORM : OP_SHIFT;
        end
    end

    // Calculation control and register file
    always_comb
    begin
        opb_next   = opb_reg;
        pkeep_next = pkeep_reg;
        done_next  = done_reg;
        err_next   = err_reg;
        ovf_next   = ovf_reg;
        dir_next   = dir_reg;
        sc_next    = sc_reg;
        armed_next = armed_reg;
        phase_next = phase_reg;
        op_next    = op_reg;
        cnt_next   = (phase_reg == PH_EXEC) ? cnt_reg - 5'h01 : cnt_reg;
        res_next   = res_reg;
        scres_next = scres_reg;
        rdata_next = rdata_reg;
        if (finish)
        begin
            // Results replace operands
            for (int i = 0; i < NUM_OPB; i++)
                opb_next[i] = res_reg[8*i +: 8];
            if (op_reg == OP_NORM)
                sc_next = scres_reg;
            done_next  = 1'b1;
            phase_next = PH_READ;
        end
        if (wr_opb)
            opb_next[idx] = SFR_WDATA;
        if (wr_arith)
        begin
            dir_next = SFR_WDATA[DIR_BIT];
            sc_next  = SFR_WDATA[SC_MSB:0];
        end
        if (SFR_WR && (SFR_ADDR == ADDR_POWER))
            pkeep_next = SFR_WDATA & POWER_WMASK;
        if (wr_opb && (idx == 3'h0))
        begin
            ovf_next   = 1'b0;
            armed_next = 1'b1;
            if (phase_reg == PH_READ)
                phase_next = PH_LOAD;
        end
        if (abort)
            phase_next = PH_LOAD;
        if (final_rd)
        begin
            phase_next = PH_LOAD;
            armed_next = 1'b0;
        end
        if ((phase_reg == PH_READ) && rd_opb)
            err_next = 1'b0;
        if (abort && armed_reg)
            err_next = 1'b1;
        if (start_op != OP_NONE)
        begin
            phase_next = PH_EXEC;
            op_next    = start_op;
            done_next  = 1'b0;
            case (start_op)
                OP_DIV32:
                begin
                    cnt_next = CYC_DIV32 - 5'h01;
                    res_next = {rem16, quot32};
                    ovf_next = (dvs == 16'h0000);
                end
                OP_DIV16:
                begin
                    cnt_next = CYC_DIV16 - 5'h01;
                    res_next = {rem16, 16'h0000, quot16};
                    ovf_next = (dvs == 16'h0000);
                end
                OP_MUL:
                begin
                    cnt_next = CYC_MUL - 5'h01;
                    res_next = {m[5], m[4], prod};
                    ovf_next = (prod > MUL_LIMIT);
                end
                OP_SHIFT:
                begin
                    cnt_next = CYC_SHIFT_BASE + 5'(({1'b0, wsc} + 6'h01) >> 1) - 5'h01;
                    res_next = {m[5], m[4], shifted};
                end
                OP_NORM:
                begin
                    cnt_next   = CYC_NORM_BASE + (lz >> 1) - 5'h01;
                    res_next   = {m[5], m[4], val32 << lz};
                    scres_next = lz;
                    ovf_next   = val32[31];
                end
                default: cnt_next = cnt_reg;
            endcase
        end
        if (SFR_RD)
        begin
            if (sel_opb)
                rdata_next = opb_reg[idx];
            else if (SFR_ADDR == ADDR_ARITH)
                rdata_next = {err_reg, ovf_reg, dir_reg, sc_reg};
            else if (SFR_ADDR == ADDR_POWER)
                rdata_next = pkeep_reg | {1'b0, done_reg, 6'h00};
            else
                rdata_next = 8'h00;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            for (int i = 0; i < NUM_OPB; i++)
                opb_reg[i] <= OPB_RESET;
            pkeep_reg <= POWER_RESET & POWER_WMASK;
            done_reg  <= POWER_RESET[DONE_BIT];
            err_reg   <= ARITH_RESET[ERR_BIT];
            ovf_reg   <= ARITH_RESET[OVF_BIT];
            dir_reg   <= ARITH_RESET[DIR_BIT];
            sc_reg    <= ARITH_RESET[SC_MSB:0];
            armed_reg <= 1'b0;
            phase_reg <= PH_LOAD;
            op_reg    <= OP_NONE;
            seq_reg   <= SEQ_NONE;
            cnt_reg   <= 5'h00;
            res_reg   <= 48'h000000000000;
            scres_reg <= 5'h00;
            rdata_reg <= 8'h00;
        end
        else
        begin
            opb_reg   <= opb_next;
            pkeep_reg <= pkeep_next;
            done_reg  <= done_next;
            err_reg   <= err_next;
            ovf_reg   <= ovf_next;
            dir_reg   <= dir_next;
            sc_reg    <= sc_next;
            armed_reg <= armed_next;
            phase_reg <= phase_next;
            op_reg    <= op_next;
            seq_reg   <= seq_next;
            cnt_reg   <= cnt_next;
            res_reg   <= res_next;
            scres_reg <= scres_next;
            rdata_reg <= rdata_next;
        end
    end

    // Checks: execution age counter
    logic [4:0] age_reg;
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            age_reg <= 5'h00;
        else if (start_op != OP_NONE)
            age_reg <= 5'h00;
        else if (phase_reg == PH_EXEC)
            age_reg <= age_reg + 5'h01;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_start;
        start_op != OP_NONE;
    endsequence
    sequence s_finish;
        finish;
    endsequence

    property p_err_set;
        abort && armed_reg |=> err_reg;
    endproperty
    a_err_set: assert property (p_err_set) else $error("write during run left error clear");

    property p_err_clr;
        (phase_reg == PH_READ) && rd_opb && !abort |=> !err_reg;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flag not cleared by read");

    property p_ovf_div0;
        s_start ##0 ((start_op == OP_DIV32 || start_op == OP_DIV16) && dvs == 16'h0000)
            |=> ovf_reg;
    endproperty
    a_ovf_div0: assert property (p_ovf_div0) else $error("divide by zero left overflow clear");
    property p_ovf_mul;
        (start_op == OP_MUL) |=> ovf_reg == (res_reg[31:0] > MUL_LIMIT);
    endproperty
    a_ovf_mul: assert property (p_ovf_mul) else $error("multiply overflow wrong");

    property p_ovf_clr;
        wr_opb && idx == 3'h0 |=> !ovf_reg;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared by byte 0 write");

    property p_ovf_ro;
        wr_arith && start_op == OP_NONE && !(wr_opb) |=> ovf_reg == $past(ovf_reg);
    endproperty
    a_ovf_ro: assert property (p_ovf_ro) else $error("overflow flag changed by write");

    property p_fixed_time;
        finish |-> ((op_reg == OP_DIV32) ? age_reg == CYC_DIV32 - 5'h01
                  : (op_reg == OP_DIV16) ? age_reg == CYC_DIV16 - 5'h01
                  : (op_reg == OP_MUL) ? age_reg == CYC_MUL - 5'h01 : 1'b1);
    endproperty
    a_fixed_time: assert property (p_fixed_time) else $error("execution time wrong");

    property p_var_time;
        finish && (op_reg == OP_SHIFT || op_reg == OP_NORM) |-> age_reg >= CYC_SHIFT_BASE && age_reg <= 5'h12;
    endproperty
    a_var_time: assert property (p_var_time) else $error("shift time out of range");

    property p_done;
        // Aborted run returns to load phase without done
        s_start |=> !done_reg ##[2:19] (done_reg || phase_reg == PH_LOAD);
    endproperty
    a_done: assert property (p_done) else $error("done flag sequence wrong");

    property p_run;
        s_start |=> CALC_BUSY;
    endproperty
    a_run: assert property (p_run) else $error("start did not begin execution");

    property p_norm;
        s_finish ##0 (op_reg == OP_NORM && res_reg[31:0] != 32'h00000000) |=> opb_reg[3][7];
    endproperty
    a_norm: assert property (p_norm) else $error("normalize left bit 7 clear");

    property p_last_read;
        final_rd |=> phase_reg == PH_LOAD && !armed_reg;
    endproperty
    a_last_read: assert property (p_last_read) else $error("final read did not end calculation");

endmodule

// ===== bench/core_model.sv
/*
 Processor-side model of the register port: byte reads and writes.
 Assumes the unit takes strobes on the rising clock edge, read data registered on that same edge.
*/
module core_model
(
    input  wire logic       clk,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_wdata,
    output logic            sfr_wr,
    output logic            sfr_rd,
    input  wire logic [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sfr_addr  = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
    end

    // Write strobe over one edge, bus scrambled after; never waits on the unit
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= dat;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        sfr_addr  <= ~a;
        sfr_wdata <= ~dat;
    endtask

    // Read strobe over one edge, data taken half a cycle later, on the falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        sfr_addr <= ~a;
        @(negedge clk);
        dat = sfr_rdata;
    endtask
endmodule

// ===== bench/muldiv_unit_tb.sv
/*
 Self-checking bench of the arithmetic unit through its register port.
 Assumes the core model in core_model.sv and the package muldiv_pkg.
*/
module muldiv_unit_tb
    import muldiv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 5000;
    logic        clk;
    logic        arst_n;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        calc_busy;
    logic [7:0]  d;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          kinds [11] = '{0, 0, 1, 2, 2, 3, 3, 3, 3, 3, 3};
    logic [31:0] xs    [11] = '{32'h12345678, 32'h0000FFFF, 32'h0000FFFF, 32'h000000FF, 32'h00000100,
                                32'h80000001, 32'hFFFFFFFF, 32'h00000001, 32'h00012345, 32'h00000001,
                                32'h80000000};
    logic [15:0] ys    [11] = '{16'h1234, 16'h0000, 16'h0007, 16'h0101, 16'h0100, 16'h0000, 16'h0000,
                                16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0]  arcs  [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3F, 8'h1F, 8'h00, 8'h20, 8'h00};

    muldiv_unit DUT
    (
        .CLK       (clk),
        .ARST_N    (arst_n),
        .SFR_ADDR  (sfr_addr),
        .SFR_WDATA (sfr_wdata),
        .SFR_WR    (sfr_wr),
        .SFR_RD    (sfr_rd),
        .SFR_RDATA (sfr_rdata),
        .CALC_BUSY (calc_busy)
    );

    core_model core
    (
        .clk       (clk),
        .sfr_addr  (sfr_addr),
        .sfr_wdata (sfr_wdata),
        .sfr_wr    (sfr_wr),
        .sfr_rd    (sfr_rd),
        .sfr_rdata (sfr_rdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_n(input string name, input int e, input int g);
        comparisons++;
        if (g != e)
        begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", name, e, g);
        end
    endtask

    // One calculation: load, wait, read back; abort breaks in during execution
    task automatic run(input int k, input logic [31:0] x, input logic [15:0] y, input logic [7:0] arc,
                       input bit abort);
        logic [7:0]  ob [6];
        logic [31:0] r;
        logic [15:0] m;
        logic        ov;
        logic [7:0]  ex;
        logic [7:0]  mk;
        int          n;
        int          lz;
        int          cnt;
        int          q [$];
        lz = 0;
        while (lz < 31 && x[31 - lz] !== 1'b1) lz++;
        ob = '{x[7:0], x[15:8], x[23:16], x[31:24], y[7:0], y[15:8]};
        m  = y;
        ov = 1'b0;
        mk = 8'hC0;
        ex = 8'h00;
        q  = '{0, 1, 2, 3};
        case (k)
            0:
            begin
                q  = '{0, 1, 2, 3, 4, 5};
                r  = (y == 16'h0000) ? 32'hFFFFFFFF : x / y;
                m  = (y == 16'h0000) ? 16'h0000 : 16'(x % y);
                ov = (y == 16'h0000);
                n  = 17;
            end
            1:
            begin
                q = '{0, 1, 4, 5};
                r = 32'(x[15:0] / y);
                m = x[15:0] % y;
                n = 9;
            end
            2:
            begin
                q  = '{0, 4, 1, 5};
                r  = 32'(x[15:0]) * 32'(y);
                ov = (r > 32'h0000FFFF);
                n  = 11;
            end
            default:
            begin
                if (arc[4:0] != 5'h00)
                begin
                    r  = arc[5] ? x >> arc[4:0] : x << arc[4:0];
                    n  = 2 + (int'(arc[4:0]) + 1) / 2;
                    mk = 8'hE0;
                    ex = {2'b00, arc[5], 5'h00};
                end
                else
                begin
                    r  = x << lz;
                    ov = x[31];
                    n  = 4 + lz / 2;
                    mk = 8'hDF;
                    ex = {2'b00, 1'b0, 5'(lz)};
                end
            end
        endcase
        ex = ex | {1'b0, ov, 6'h00};
        foreach (q[i]) core.wr(ADDR_OPB0 + 8'(q[i]), ob[q[i]]);
        if (k == 3) core.wr(ADDR_ARITH, arc);
        if (abort)
        begin
            core.rd(ADDR_POWER, d);
            chk("done_at_start", 8'h00, d & 8'h40);
            core.wr(ADDR_OPB0, 8'h00);
            core.rd(ADDR_ARITH, d);
            chk("error_flag", 8'h80, d & 8'h80);
            repeat (20) @(posedge clk);
            core.rd(ADDR_POWER, d);
            chk("done_after_abort", 8'h00, d & 8'h40);
            return;
        end
        @(negedge clk);
        for (cnt = 0; calc_busy === 1'b1 && cnt < 40; cnt++) @(negedge clk);
        chk_n("busy_cycles", n, cnt);
        core.rd(ADDR_POWER, d);
        chk("done_flag", 8'h40, d);
        if (k < 2)
            q = '{0, 1, 2, 3, 4, 5};
        else if (k == 2)
            q = '{0, 1, 2, 4, 5, 3};
        ob = '{r[7:0], r[15:8], r[23:16], r[31:24], m[7:0], m[15:8]};
        foreach (q[i])
        begin
            core.rd(ADDR_OPB0 + 8'(q[i]), d);
            chk($sformatf("result_byte_%0d", q[i]), ob[q[i]], d);
        end
        core.rd(ADDR_ARITH, d);
        chk("arith_flags", ex & mk, d & mk);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        core.rd(ADDR_POWER, d);
        chk("power_reset", POWER_RESET, d);
        for (int i = 0; i <= NUM_OPB; i++)
        begin
            core.rd(ADDR_OPB0 + 8'(i), d);
            chk("reset_value", 8'h00, d);
        end
        core.rd(ADDR_OPB0 - 8'h01, d);
        chk("unmapped", 8'h00, d);
        core.wr(ADDR_ARITH, 8'hFF);
        core.rd(ADDR_ARITH, d);
        chk("arith_ro_bits", 8'h3F, d);
        core.wr(ADDR_POWER, 8'hFF);
        core.rd(ADDR_POWER, d);
        chk("power_write", 8'hC3, d);
        core.wr(ADDR_POWER, 8'h00);
        core.rd(ADDR_POWER, d);
        chk("power_done_ro", 8'h40, d);
        run(0, 32'h01020304, 16'h0102, 8'h00, 1'b1);
        for (int i = 0; i < 11; i++) run(kinds[i], xs[i], ys[i], arcs[i], 1'b0);
        core.wr(ADDR_OPB0, 8'h00);
        core.rd(ADDR_ARITH, d);
        chk("overflow_clear", 8'h00, d & 8'h40);
        close_out();
    end
endmodule
